//--- hw/srbp_defs.vh
// Constants for the system reset, supply droop and code read guard block.
// Assumes a single 20 MHz clock and a plain register port with one-cycle strobes.
// Summary of operation
// - Chip reset is requested by pin, watchdog, power-on or supply droop detector.
// - Any reset restarts wake-up timer; release waits pin, oscillator, count, flash init.
// - On release mapping and wake enable registers hold defaults, edge flags keep their value; fetch starts at address zero from boot block.
// - Supply below first threshold raises droop interrupt request toward vectored_irq_controller.
// - First-stage droop condition is readable in a status register for polling.
// - Supply below second threshold asserts chip reset and blocks flash modification.
// - Droop reset holds down to about one volt; power-on reset overlaps with no gap.
// - Guard level comes from a flash pattern; in_application_programming always unrestricted.
// - Level one blocks JTAG; limited programming command set, sector zero protected.
// - Level two blocks JTAG; programming allows only full erase then update.
// - Level three blocks JTAG and programming; programming_override_pin is ignored.
// - Fifty edge and four level external interrupts, each optionally a wake-up source.
// - Mapping control selects boot ROM, SRAM or external memory for vectors.
`ifndef SRBP_DEFS_VH
`define SRBP_DEFS_VH
`define SRBP_CLK_MHZ 20
`define SRBP_WAKE_CLOCKS 16'h0100
`define SRBP_ADDR_STATUS 4'h0
`define SRBP_ADDR_MAP 4'h1
`define SRBP_ADDR_EDGE_LO 4'h2
`define SRBP_ADDR_EDGE_HI 4'h3
`define SRBP_ADDR_LEVEL 4'h4
`define SRBP_ADDR_WAKE_LO 4'h5
`define SRBP_ADDR_WAKE_HI 4'h6
`define SRBP_ADDR_FLAGS_LO 4'h7
`define SRBP_ADDR_FLAGS_HI 4'h8
`define SRBP_ADDR_GUARD 4'h9
`define SRBP_MAP_BOOT 2'h0
`define SRBP_MAP_SRAM 2'h1
`define SRBP_MAP_EXT 2'h2
`define SRBP_MAP_RESET 2'h0
`define SRBP_PAT_L1 32'h1234_5678
`define SRBP_PAT_L2 32'h8765_4321
`define SRBP_PAT_L3 32'h4321_8765
`define SRBP_GUARD_NONE 2'h0
`define SRBP_GUARD_L1 2'h1
`define SRBP_GUARD_L2 2'h2
`define SRBP_GUARD_L3 2'h3
`define SRBP_N_EDGE 50
`define SRBP_N_LEVEL 4
`endif

//--- hw/srbp_sync.v
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes clk is the system clock and rst_n is asynchronous, active low.
`timescale 1ns/1ns
module srbp_sync #(parameter W = 1)
(
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   // First stage feeds only the second stage.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= {W{1'b0}};
         q <= {W{1'b0}};
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

//--- hw/srbp_top.v
// System reset sequencer, supply droop monitor, code read guard and wake logic.
// Assumes all pin and analogue comparator inputs are asynchronous to clk.
`timescale 1ns/1ns
`include "srbp_defs.vh"
module srbp_top
(
   input wire clk,
   input wire rst_n,
   input wire reset_pin_n,
   input wire watchdog_reset,
   input wire power_on_reset,
   input wire droop_stage_one,
   input wire droop_stage_two,
   input wire osc_running,
   input wire flash_init_done,
   input wire [31:0] guard_pattern,
   input wire guard_pattern_valid,
   input wire programming_override_pin,
   input wire [49:0] edge_irq_in,
   input wire [3:0] level_irq_in,
   input wire power_down,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   output reg chip_reset_n,
   output reg flash_write_block,
   output reg droop_irq,
   output reg [31:0] fetch_addr,
   output reg [1:0] vector_map,
   output reg jtag_enable,
   output reg isp_enable,
   output reg isp_limited,
   output reg isp_erase_only,
   output reg isp_sector0_lock,
   output reg iap_enable,
   output reg isp_override_accept,
   output reg wake_up,
   output reg [49:0] edge_irq_flag,
   output reg [3:0] level_irq_active
);
   localparam ST_HOLD = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_RUN = 3'b100;

   wire [8:0] sync_out;
   wire [49:0] edge_s;
   wire [3:0] level_s;
   wire pin_n_s;
   wire wdt_s;
   wire por_s;
   wire droop1_s;
   wire droop2_s;
   wire osc_s;
   wire flash_s;
   wire override_s;
   wire any_reset;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [15:0] wake_count;
   reg [1:0] rel_sync;
   reg [1:0] guard;
   reg [49:0] edge_prev;
   reg [49:0] edge_en_wake;
   reg [3:0] level_en_wake;
   reg [1:0] map_ctrl;
   reg [49:0] next_flags;

   // Synchronise single-bit pins and comparators.
   srbp_sync #(.W(9)) u_sync_ctl
   (
      .clk(clk),
      .rst_n(rst_n),
      .d({reset_pin_n, watchdog_reset, power_on_reset, droop_stage_one, droop_stage_two,
          osc_running, flash_init_done, programming_override_pin, 1'b0}),
      .q(sync_out)
   );

   // Synchronise external interrupt inputs.
   srbp_sync #(.W(54)) u_sync_irq
   (
      .clk(clk),
      .rst_n(rst_n),
      .d({edge_irq_in, level_irq_in}),
      .q({edge_s, level_s})
   );

   assign pin_n_s = sync_out[8];
   assign wdt_s = sync_out[7];
   assign por_s = sync_out[6];
   assign droop1_s = sync_out[5];
   assign droop2_s = sync_out[4];
   assign osc_s = sync_out[3];
   assign flash_s = sync_out[2];
   assign override_s = sync_out[1];

   // Combined reset request; power-on and droop overlap so no gap appears.
   assign any_reset = !pin_n_s | wdt_s | por_s | droop2_s;

   // Decodes a flash pattern into a guard level.
   function [1:0] srbp_decode_guard;
      input [31:0] pat;
      begin
         if (pat == `SRBP_PAT_L1)
            srbp_decode_guard = `SRBP_GUARD_L1;
         else if (pat == `SRBP_PAT_L2)
            srbp_decode_guard = `SRBP_GUARD_L2;
         else if (pat == `SRBP_PAT_L3)
            srbp_decode_guard = `SRBP_GUARD_L3;
         else
            srbp_decode_guard = `SRBP_GUARD_NONE;
      end
   endfunction

   // Next state of the reset sequencer.
   always @*
   begin
      next_state = state;
      case (state)
         ST_HOLD:
         begin
            if (!any_reset)
               next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (any_reset)
               next_state = ST_HOLD;
            else if (osc_s && flash_s && wake_count == `SRBP_WAKE_CLOCKS)
               next_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (any_reset)
               next_state = ST_HOLD;
         end
         default:
            next_state = ST_HOLD;
      endcase
   end

   // Sequencer state and wake-up timer; any reset restarts the count.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_HOLD;
         wake_count <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         if (any_reset || state != ST_WAIT)
            wake_count <= 16'h0000;
         else if (osc_s && wake_count != `SRBP_WAKE_CLOCKS)
            wake_count <= wake_count + 16'h0001;
      end
   end

   // Release pipeline clears at once on any request; the reset output drops and rises on a clock edge.
   always @(posedge clk or posedge any_reset)
   begin
      if (any_reset)
         rel_sync <= 2'b00;
      else
         rel_sync <= {rel_sync[0], state == ST_RUN};
   end

   // Reset output and flash write block follow the sequencer.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chip_reset_n <= 1'b0;
         flash_write_block <= 1'b1;
         fetch_addr <= 32'h0000_0000;
         droop_irq <= 1'b0;
      end
      else
      begin
         chip_reset_n <= rel_sync[1] & !any_reset;
         flash_write_block <= droop2_s | !rel_sync[1];
         fetch_addr <= 32'h0000_0000;
         droop_irq <= droop1_s;
      end
   end

   // Guard level is captured from flash once flash has initialised.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         guard <= `SRBP_GUARD_L3;
      else if (state != ST_RUN && flash_s && guard_pattern_valid)
         guard <= srbp_decode_guard(guard_pattern);
   end

   // Access permissions for debug and programming by guard level.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         jtag_enable <= 1'b0;
         isp_enable <= 1'b0;
         isp_limited <= 1'b0;
         isp_erase_only <= 1'b0;
         isp_sector0_lock <= 1'b0;
         iap_enable <= 1'b0;
         isp_override_accept <= 1'b0;
      end
      else
      begin
         iap_enable <= rel_sync[1];
         jtag_enable <= guard == `SRBP_GUARD_NONE;
         isp_enable <= guard != `SRBP_GUARD_L3;
         isp_limited <= guard == `SRBP_GUARD_L1;
         isp_sector0_lock <= guard == `SRBP_GUARD_L1;
         isp_erase_only <= guard == `SRBP_GUARD_L2;
         isp_override_accept <= override_s && guard != `SRBP_GUARD_L3;
      end
   end

   // Edge flags set on rising edges; set wins over a software clear.
   always @*
   begin
      next_flags = edge_irq_flag;
      if (wr && addr == `SRBP_ADDR_FLAGS_LO)
         next_flags[31:0] = edge_irq_flag[31:0] & ~wdata;
      if (wr && addr == `SRBP_ADDR_FLAGS_HI)
         next_flags[49:32] = edge_irq_flag[49:32] & ~wdata[17:0];
      next_flags = next_flags | (edge_s & ~edge_prev);
   end

   // External interrupt tracking and power-down wake.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edge_prev <= 50'd0;
         edge_irq_flag <= 50'd0;
         level_irq_active <= 4'h0;
         wake_up <= 1'b0;
      end
      else
      begin
         edge_prev <= edge_s;
         edge_irq_flag <= next_flags;
         level_irq_active <= level_s;
         wake_up <= power_down && ((|(edge_s & ~edge_prev & edge_en_wake)) | (|(level_s & level_en_wake)));
      end
   end

   // Software registers: mapping control and wake enables.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         map_ctrl <= `SRBP_MAP_RESET;
         edge_en_wake <= 50'd0;
         level_en_wake <= 4'h0;
         vector_map <= `SRBP_MAP_RESET;
      end
      else if (!chip_reset_n)
      begin
         map_ctrl <= `SRBP_MAP_RESET;
         edge_en_wake <= 50'd0;
         level_en_wake <= 4'h0;
         vector_map <= `SRBP_MAP_BOOT;
      end
      else
      begin
         vector_map <= map_ctrl;
         if (wr && addr == `SRBP_ADDR_MAP && wdata[1:0] != 2'h3)
            map_ctrl <= wdata[1:0];
         if (wr && addr == `SRBP_ADDR_WAKE_LO)
            edge_en_wake[31:0] <= wdata;
         if (wr && addr == `SRBP_ADDR_WAKE_HI)
            edge_en_wake[49:32] <= wdata[17:0];
         if (wr && addr == `SRBP_ADDR_LEVEL)
            level_en_wake <= wdata[3:0];
      end
   end

   // Read data appear one cycle after the read strobe; unmapped reads zero.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 32'h0000_0000;
      else if (rd)
      begin
         case (addr)
            `SRBP_ADDR_STATUS: rdata <= {29'd0, droop2_s, any_reset, droop1_s};
            `SRBP_ADDR_MAP: rdata <= {30'd0, map_ctrl};
            `SRBP_ADDR_LEVEL: rdata <= {24'd0, level_s, level_en_wake};
            `SRBP_ADDR_WAKE_LO: rdata <= edge_en_wake[31:0];
            `SRBP_ADDR_WAKE_HI: rdata <= {14'd0, edge_en_wake[49:32]};
            `SRBP_ADDR_FLAGS_LO: rdata <= edge_irq_flag[31:0];
            `SRBP_ADDR_FLAGS_HI: rdata <= {14'd0, edge_irq_flag[49:32]};
            `SRBP_ADDR_GUARD: rdata <= {30'd0, guard};
            default: rdata <= 32'h0000_0000;
         endcase
      end
      else
         rdata <= 32'h0000_0000;
   end
endmodule

//--- dv/srbp_properties.sv
// Checker for the reset, supply droop and guard outputs of srbp_top.
// Assumes it is bound to srbp_top and sees only its ports.
`timescale 1ns/1ns
module srbp_chk
(
   input wire clk,
   input wire rst_n,
   input wire reset_pin_n,
   input wire watchdog_reset,
   input wire power_on_reset,
   input wire droop_stage_one,
   input wire droop_stage_two,
   input wire osc_running,
   input wire flash_init_done,
   input wire chip_reset_n,
   input wire flash_write_block,
   input wire droop_irq,
   input wire [31:0] fetch_addr,
   input wire [1:0] vector_map,
   input wire jtag_enable,
   input wire isp_enable,
   input wire isp_limited,
   input wire isp_erase_only,
   input wire iap_enable,
   input wire isp_override_accept
);
   reg [9:0] calm;
   wire src = !reset_pin_n || watchdog_reset || power_on_reset || droop_stage_two;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Counts quiet cycles with the oscillator running, so an early release is caught.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         calm <= 10'h000;
      else if (src || !osc_running)
         calm <= 10'h000;
      else if (calm != 10'h3ff)
         calm <= calm + 10'h001;
   end
   src_reset_a: assert property (src |-> ##[1:4] !chip_reset_n)
      else $error("reset source did not hold chip reset");
   release_wait_a: assert property ($rose(chip_reset_n) |-> calm >= 10'h100 && flash_init_done)
      else $error("chip reset released too early");
   fetch_zero_a: assert property (fetch_addr == 32'h0000_0000)
      else $error("fetch address not zero");
   droop_irq_a: assert property ($rose(droop_stage_one) |-> ##[1:4] droop_irq)
      else $error("droop interrupt missing");
   flash_lock_a: assert property (droop_stage_two |-> ##[1:4] flash_write_block)
      else $error("flash not blocked under deep droop");
   iap_free_a: assert property (chip_reset_n && $past(chip_reset_n) |-> iap_enable)
      else $error("application programming restricted");
   guard_jtag_a: assert property ((isp_limited || isp_erase_only) |-> !jtag_enable)
      else $error("debug port open under guard");
   override_off_a: assert property (isp_override_accept |-> isp_enable)
      else $error("override accepted with programming off");
   map_legal_a: assert property (vector_map != 2'h3)
      else $error("illegal vector map");
endmodule
bind srbp_top srbp_chk u_chk (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
   .watchdog_reset(watchdog_reset), .power_on_reset(power_on_reset), .droop_stage_one(droop_stage_one),
   .droop_stage_two(droop_stage_two), .osc_running(osc_running), .flash_init_done(flash_init_done),
   .chip_reset_n(chip_reset_n), .flash_write_block(flash_write_block), .droop_irq(droop_irq),
   .fetch_addr(fetch_addr), .vector_map(vector_map), .jtag_enable(jtag_enable), .isp_enable(isp_enable),
   .isp_limited(isp_limited), .isp_erase_only(isp_erase_only), .iap_enable(iap_enable),
   .isp_override_accept(isp_override_accept));

//--- dv/srbp_far.sv
// Model of the reset pin, supply monitor, oscillator and flash controller.
// Assumes the bench steers it through req and lvl on the system clock.
`timescale 1ns/1ns
`include "srbp_defs.vh"
module srbp_far
(
   input wire clk,
   input wire [4:0] req,
   input wire [1:0] lvl,
   output reg reset_pin_n = 1'b1,
   output reg watchdog_reset = 1'b0,
   output reg power_on_reset = 1'b0,
   output reg droop_stage_one = 1'b0,
   output reg droop_stage_two = 1'b0,
   output reg osc_running = 1'b0,
   output reg flash_init_done = 1'b0,
   output reg [31:0] guard_pattern = 32'h0000_0000,
   output reg guard_pattern_valid = 1'b0
);
   reg [3:0] fl_cnt = 4'h8;
   reg [31:0] pat;
   // Picks the flash word that selects each guard level.
   always @*
   begin
      case (lvl)
         2'h1: pat = `SRBP_PAT_L1;
         2'h2: pat = `SRBP_PAT_L2;
         2'h3: pat = `SRBP_PAT_L3;
         default: pat = 32'h0000_0000;
      endcase
   end
   // Flash init restarts slowly after any reset; the word toggles while it is not valid.
   always @(posedge clk)
   begin
      reset_pin_n <= !req[0];
      watchdog_reset <= req[1];
      power_on_reset <= req[2];
      droop_stage_two <= req[3];
      droop_stage_one <= req[4] || req[3];
      osc_running <= !req[2];
      fl_cnt <= (req[3:0] != 4'h0) ? 4'h8 : fl_cnt - {3'h0, fl_cnt != 4'h0};
      flash_init_done <= (fl_cnt == 4'h0);
      guard_pattern_valid <= flash_init_done;
      guard_pattern <= flash_init_done ? pat : ~guard_pattern;
   end
endmodule

//--- dv/test_system_reset_brownout_protect.sv
// Self-checking bench for srbp_top with the far-side model.
// Assumes srbp_defs.vh is on the include path.
`timescale 1ns/1ns
`include "srbp_defs.vh"
module test_system_reset_brownout_protect;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [4:0] req = 5'h00;
   reg [1:0] lvl = 2'h0;
   reg ovr = 1'b1;
   reg [49:0] edg = 50'h0;
   reg [3:0] lvi = 4'h0;
   reg pd = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0000_0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg rd_q = 1'b0;
   integer miscompares = 0;
   integer checks = 0;
   logic [31:0] expq[$];
   wire [31:0] rdata, fetch_addr, gp;
   wire [1:0] vector_map;
   wire [49:0] eif;
   wire [3:0] lia;
   wire crn, fwb, dirq, jt, ie, il, ieo, is0, in_application_programming, iov, wk, rpn, wd, por, d1, d2, osc, fid, gpv;
   srbp_far u_far (.clk(clk), .req(req), .lvl(lvl), .reset_pin_n(rpn), .watchdog_reset(wd), .power_on_reset(por),
      .droop_stage_one(d1), .droop_stage_two(d2), .osc_running(osc), .flash_init_done(fid), .guard_pattern(gp),
      .guard_pattern_valid(gpv));
   srbp_top u_dut (.clk(clk), .rst_n(rst_n), .reset_pin_n(rpn), .watchdog_reset(wd), .power_on_reset(por),
      .droop_stage_one(d1), .droop_stage_two(d2), .osc_running(osc), .flash_init_done(fid), .guard_pattern(gp),
      .guard_pattern_valid(gpv), .programming_override_pin(ovr), .edge_irq_in(edg), .level_irq_in(lvi),
      .power_down(pd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_reset_n(crn),
      .flash_write_block(fwb), .droop_irq(dirq), .fetch_addr(fetch_addr), .vector_map(vector_map),
      .jtag_enable(jt), .isp_enable(ie), .isp_limited(il), .isp_erase_only(ieo), .isp_sector0_lock(is0),
      .iap_enable(in_application_programming), .isp_override_accept(iov), .wake_up(wk), .edge_irq_flag(eif), .level_irq_active(lia));
   // Makes the 50 ns system clock.
   initial
   begin
      forever #25 clk = ~clk;
   end
   task final_report;
   begin
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
   end
   endtask
   task cyc(input integer n);
   begin
      repeat (n) @(posedge clk);
   end
   endtask
   task wreg(input [3:0] a, input [31:0] d);
   begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      cyc(1);
      wr <= 1'b0;
      cyc(1);
   end
   endtask
   task rreg(input [3:0] a, input [31:0] e);
   begin
      expq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      cyc(1);
      rd <= 1'b0;
      cyc(1);
   end
   endtask
   task wait_up(output integer n);
   begin
      n = 0;
      while (crn !== 1'b1 && n < 2000)
      begin
         cyc(1);
         n = n + 1;
      end
      if (n >= 2000)
      begin
         miscompares = miscompares + 1;
         final_report;
      end
   end
   endtask
   // Compares read data in the cycle after each read strobe against the oldest note.
   always @(posedge clk)
   begin
      rd_q <= rd;
      if (rd_q)
         chk("rdata", expq.pop_front(), rdata);
   end
   // Main sequence.
   initial
   begin
      integer i, n, k;
      n = $urandom(32'h1c2c);
      cyc(10);
      rst_n <= 1'b1;
      wait_up(n);
      chk("fetch", 32'h0000_0000, fetch_addr);
      chk("vmap", `SRBP_MAP_RESET, vector_map);
      rreg(`SRBP_ADDR_STATUS, 32'h0000_0000);
      req <= 5'h10;
      cyc(5);
      chk("dirq", 1, dirq);
      rreg(`SRBP_ADDR_STATUS, 32'h0000_0001);
      for (i = 0; i < 5; i = i + 1)
      begin
         req <= (i == 4) ? 5'h0c : 5'h01 << i;
         cyc(6);
         if (i == 4)
            req <= 5'h04;
         cyc(6);
         chk("crst", 0, crn);
         chk("fblk", 1, fwb);
         req <= 5'h00;
         wait_up(n);
         chk("wait", 1, n >= `SRBP_WAKE_CLOCKS);
         chk("fblk", 0, fwb);
      end
      for (i = 3; i >= 0; i = i - 1)
      begin
         lvl <= i;
         ovr <= (i != 0);
         req <= 5'h04;
         cyc(6);
         req <= 5'h00;
         wait_up(n);
         chk("jtag", i == 0, jt);
         chk("isp", {il, ieo, is0, ie}, {i == 1, i == 2, i == 1, i != 3});
         chk("iap", {in_application_programming, iov}, {1'b1, ovr && i != 3});
         rreg(`SRBP_ADDR_GUARD, i);
      end
      for (i = 0; i < 3; i = i + 1)
      begin
         k = $urandom % 3;
         wreg(`SRBP_ADDR_MAP, k);
         wreg(`SRBP_ADDR_MAP, 32'h0000_0003);
         rreg(`SRBP_ADDR_MAP, k);
         chk("vmap", k, vector_map);
      end
      k = $urandom % 50;
      wreg((k < 32) ? `SRBP_ADDR_WAKE_LO : `SRBP_ADDR_WAKE_HI, 32'h1 << (k % 32));
      pd <= 1'b1;
      edg <= 50'h1 << k;
      n = 0;
      for (i = 0; i < 6; i = i + 1)
      begin
         cyc(1);
         n = n | wk;
      end
      chk("ewake", 1, n);
      chk("eflg", 1, eif == (50'h1 << k));
      edg <= 50'h0;
      rreg((k < 32) ? `SRBP_ADDR_FLAGS_LO : `SRBP_ADDR_FLAGS_HI, 32'h1 << (k % 32));
      wreg((k < 32) ? `SRBP_ADDR_FLAGS_LO : `SRBP_ADDR_FLAGS_HI, 32'h1 << (k % 32));
      rreg((k < 32) ? `SRBP_ADDR_FLAGS_LO : `SRBP_ADDR_FLAGS_HI, 32'h0000_0000);
      chk("eflg", 0, |eif);
      wreg(`SRBP_ADDR_LEVEL, 32'h0000_0001);
      pd <= 1'b1;
      lvi <= 4'h1;
      n = 0;
      for (i = 0; i < 10; i = i + 1)
      begin
         cyc(1);
         n = n | wk;
      end
      chk("wake", 1, n);
      chk("lvl", 1, lia);
      rreg(`SRBP_ADDR_LEVEL, 32'h0000_0011);
      cyc(4);
      final_report;
   end
endmodule
